// *** pkg/ept_pkg.sv ***
/*
 * Shared constants for the eight bit period timer: register map, field
 * positions, reset values, mode codes and the control state encoding.
 * Assumes one clock domain and the plain strobe register port.
 */
package ept_pkg;
   // ************************************************************
   // Widths
   // ************************************************************
   localparam int DATA_W = 8;
   localparam int ADDR_W = 3;
   localparam int PRE_W = 3;
   localparam int PRE_CNT_W = 7;
   localparam int POST_W = 4;
   localparam int MODE_W = 5;

   // ************************************************************
   // Register offsets
   // ************************************************************
   localparam logic [ADDR_W-1:0] ADR_COUNT = 3'h0;
   localparam logic [ADDR_W-1:0] ADR_LIMIT = 3'h1;
   localparam logic [ADDR_W-1:0] ADR_CTRL = 3'h2;
   localparam logic [ADDR_W-1:0] ADR_MODE = 3'h3;
   localparam logic [ADDR_W-1:0] ADR_STAT = 3'h4;

   // ************************************************************
   // Fields and reset values
   // ************************************************************
   localparam int CTRL_RUN = 7;
   localparam int CTRL_PRE_LSB = 4;
   localparam int CTRL_POST_LSB = 0;
   localparam int STAT_FLAG = 0;
   localparam int STAT_RUN = 1;
   localparam int STAT_WAIT = 2;
   localparam logic [DATA_W-1:0] COUNT_RST = 8'h00;
   localparam logic [DATA_W-1:0] LIMIT_RST = 8'hff;
   localparam logic [DATA_W-1:0] CTRL_RST = 8'h00;
   localparam logic [MODE_W-1:0] MODE_RST = 5'h00;

   // ************************************************************
   // Mode families (upper two bits of the mode field)
   // ************************************************************
   localparam logic [1:0] FAM_FREE = 2'h0;
   localparam logic [1:0] FAM_ONE = 2'h1;
   localparam logic [1:0] FAM_MONO = 2'h2;

   // ************************************************************
   // External trigger timing, in timer clock periods
   // ************************************************************
   localparam int ERS_EDGE_GAP_CYC = 6;
   localparam int ERS_LEVEL_CYC = 3;

   typedef enum logic [2:0] {
      ST_IDLE = 3'b001,
      ST_WAIT = 3'b010,
      ST_RUN = 3'b100
   } ept_state_e;
endpackage

// *** pkg/ept_tick_if.sv ***
/*
 * Carrier between the timer core and its prescaler: clear, enable,
 * ratio select going down, the prescaled tick coming back.
 * Assumes both ends sit on the same clock.
 */
`timescale 1ns/10ps
interface ept_tick_if;
   logic clear;
   logic enable;
   logic [ept_pkg::PRE_W-1:0] sel;
   logic tick;
   modport ctl (output clear, output enable, output sel, input tick);
   modport pre (input clear, input enable, input sel, output tick);
endinterface

// *** rtl/ept_prescaler.sv ***
/*
 * Programmable prescaler: one tick every 2**sel enabled clock cycles.
 * Assumes the core clears it on count and control register writes and timer resets.
 */
`timescale 1ns/10ps
module ept_prescaler (
   // Clock and reset
   input wire logic clock,
   input wire logic nrst,
   // Core side
   ept_tick_if.pre pi
);
   import ept_pkg::*;

   logic [PRE_CNT_W-1:0] cnt;
   logic [PRE_CNT_W-1:0] next_cnt;
   logic [PRE_CNT_W-1:0] mask;

   // ************************************************************
   // Divider
   // ************************************************************
   // Ratio 1:1 up to 1:128
   assign mask = PRE_CNT_W'((8'h01 << pi.sel) - 8'h01);
   assign pi.tick = pi.enable && !pi.clear && (cnt == mask);

   always_comb begin
      next_cnt = cnt;
      if (pi.clear) begin
         next_cnt = '0;
      end else if (pi.enable) begin
         if (cnt >= mask) begin
            next_cnt = '0;
         end else begin
            next_cnt = PRE_CNT_W'(cnt + 7'h01);
         end
      end
   end

   always_ff @(posedge clock or negedge nrst) begin
      if (!nrst) begin
         cnt <= '0;
      end else begin
         cnt <= next_cnt;
      end
   end
endmodule

// *** rtl/ept_timer.sv ***
/*
 * Eight bit period timer with prescaler, postscaler, hardware limit
 * modes (free running, one-shot, monostable) and an external reset or
 * gate input. Assumes a 40 MHz clock, the plain strobe register port,
 * and a debug freeze level from logic on the same clock.
 */
// Local design decisions: the placing of the registers and strobed register access.
`timescale 1ns/10ps
module ept_timer (
   // Clock and reset
   input wire logic clock,
   input wire logic nrst,
   // Register port
   input wire logic [ept_pkg::ADDR_W-1:0] addr,
   input wire logic [ept_pkg::DATA_W-1:0] wdata,
   input wire logic wr,
   input wire logic rd,
   output logic [ept_pkg::DATA_W-1:0] rdata,
   // External trigger and debug
   input wire logic external_reset_signal,
   input wire logic debug_freeze,
   // Event outputs
   output logic period_event_pulse,
   output logic period_flag,
   output logic [ept_pkg::DATA_W-1:0] count_value
);
   import ept_pkg::*;

   // ************************************************************
   // Declarations
   // ************************************************************
   logic [DATA_W-1:0] period_count, next_period_count;
   logic [DATA_W-1:0] period_limit, next_period_limit;
   logic run_bit, next_run_bit;
   logic [PRE_W-1:0] pre_sel, next_pre_sel;
   logic [POST_W-1:0] postscale_match_value, next_postscale_match_value;
   logic [MODE_W-1:0] limit_mode_control, next_limit_mode_control;
   logic [POST_W-1:0] post_cnt, next_post_cnt;
   logic next_pulse, next_flag;
   logic [DATA_W-1:0] next_rdata;
   ept_state_e state, next_state;
   logic ers_s1, ers_s2, ers_s3;
   logic ev_rise, ev_fall, ev_hi, ev_lo;
   logic [1:0] fam;
   logic [2:0] var_sel;
   logic gate_mode, gate_ok, reset_ev, start_ev, need_start;
   logic wr_count, wr_ctrl, rst_act, counting, tick, match, post_hit;
   ept_tick_if pi ();

   // ************************************************************
   // Trigger synchroniser
   // ************************************************************
   // Second stage feeds the edge detector so the first stage stays clean
   always_ff @(posedge clock or negedge nrst) begin
      if (!nrst) begin
         ers_s1 <= 1'b0;
         ers_s2 <= 1'b0;
         ers_s3 <= 1'b0;
      end else begin
         ers_s1 <= external_reset_signal;
         ers_s2 <= ers_s1;
         ers_s3 <= ers_s2;
      end
   end

   // Freeze masks every trigger view
   always_comb begin
      ev_rise = !debug_freeze && ers_s2 && !ers_s3;
      ev_fall = !debug_freeze && !ers_s2 && ers_s3;
      ev_hi = !debug_freeze && ers_s2;
      ev_lo = !debug_freeze && !ers_s2;
   end

   // ************************************************************
   // Mode decode
   // ************************************************************
   // Edge modes count on one detection per edge, fine at 6 clock spacing
   assign fam = limit_mode_control[4:3];
   assign var_sel = limit_mode_control[2:0];

   always_comb begin
      gate_mode = 1'b0;
      gate_ok = 1'b1;
      reset_ev = 1'b0;
      start_ev = 1'b0;
      need_start = 1'b0;
      case (fam)
         FAM_ONE: begin
            need_start = (var_sel != 3'h0);
            case (var_sel)
               3'h1, 3'h4, 3'h6: start_ev = ev_rise;
               3'h2, 3'h5, 3'h7: start_ev = ev_fall;
               3'h3: start_ev = ev_rise || ev_fall;
               default: start_ev = 1'b0;
            endcase
            case (var_sel)
               3'h4: reset_ev = ev_rise;
               3'h5: reset_ev = ev_fall;
               3'h6: reset_ev = ev_lo;
               3'h7: reset_ev = ev_hi;
               default: reset_ev = 1'b0;
            endcase
         end
         FAM_MONO: begin
            // Reserved variants 4 to 7 wait in ST_WAIT with no start event
            need_start = (var_sel != 3'h0);
            case (var_sel)
               3'h1: start_ev = ev_rise;
               3'h2: start_ev = ev_fall;
               3'h3: start_ev = ev_rise || ev_fall;
               default: start_ev = 1'b0;
            endcase
         end
         default: begin
            case (var_sel)
               3'h1: begin
                  gate_mode = 1'b1;
                  gate_ok = ev_hi;
               end
               3'h2: begin
                  gate_mode = 1'b1;
                  gate_ok = ev_lo;
               end
               3'h3: reset_ev = ev_rise || ev_fall;
               3'h4: reset_ev = ev_rise;
               3'h5: reset_ev = ev_fall;
               3'h6: reset_ev = ev_lo;
               3'h7: reset_ev = ev_hi;
               default: reset_ev = 1'b0;
            endcase
         end
      endcase
   end

   // ************************************************************
   // Prescaler hookup
   // ************************************************************
   assign wr_count = wr && (addr == ADR_COUNT);
   assign wr_ctrl = wr && (addr == ADR_CTRL);
   assign rst_act = run_bit && reset_ev;
   // A held gate or a frozen core stops the prescaler as well
   assign counting = (state == ST_RUN) && gate_ok && !debug_freeze;
   assign pi.clear = wr_count || wr_ctrl || rst_act;
   assign pi.enable = counting;
   assign pi.sel = pre_sel;
   assign tick = pi.tick;
   assign match = tick && (period_count == period_limit);
   assign post_hit = (post_cnt == postscale_match_value);

   ept_prescaler u_pre (
      .clock(clock),
      .nrst(nrst),
      .pi(pi)
   );

   // ************************************************************
   // Registers, counters and control state
   // ************************************************************
   always_comb begin
      next_period_count = period_count;
      next_period_limit = period_limit;
      next_run_bit = run_bit;
      next_pre_sel = pre_sel;
      next_postscale_match_value = postscale_match_value;
      next_limit_mode_control = limit_mode_control;
      next_post_cnt = post_cnt;
      next_pulse = 1'b0;
      next_state = state;
      // Count: software write beats a timer reset, which beats a tick
      if (wr_count) begin
         next_period_count = wdata;
      end else if (rst_act) begin
         next_period_count = '0;
      end else if (match) begin
         next_period_count = '0;
      end else if (tick) begin
         next_period_count = DATA_W'(period_count + 8'h01);
      end
      if (wr && (addr == ADR_LIMIT)) begin
         next_period_limit = wdata;
      end
      if (wr && (addr == ADR_MODE)) begin
         next_limit_mode_control = wdata[MODE_W-1:0];
      end
      // Postscaler: 1:1 up to 1:16
      if (pi.clear) begin
         next_post_cnt = '0;
      end else if (match) begin
         if (post_hit) begin
            next_post_cnt = '0;
            next_pulse = 1'b1;
         end else begin
            next_post_cnt = POST_W'(post_cnt + 4'h1);
         end
      end
      // Control state
      case (state)
         ST_IDLE: begin
            if (run_bit) begin
               next_state = need_start ? ST_WAIT : ST_RUN;
            end
         end
         ST_WAIT: begin
            if (start_ev) begin
               next_state = ST_RUN;
            end
         end
         ST_RUN: begin
            if (match && (fam == FAM_ONE)) begin
               next_run_bit = 1'b0;
               next_state = ST_IDLE;
            end else if (match && (fam == FAM_MONO)) begin
               next_state = ST_WAIT;
            end
         end
         default: next_state = ST_IDLE;
      endcase
      if (!run_bit) begin
         next_state = ST_IDLE;
      end
      // Software write wins over the hardware clear of the run bit
      if (wr_ctrl) begin
         next_run_bit = wdata[CTRL_RUN];
         next_pre_sel = wdata[CTRL_PRE_LSB +: PRE_W];
         next_postscale_match_value = wdata[CTRL_POST_LSB +: POST_W];
      end
   end

   // Set wins over a same-cycle write-one clear
   always_comb begin
      next_flag = period_flag;
      if (wr && (addr == ADR_STAT) && wdata[STAT_FLAG]) begin
         next_flag = 1'b0;
      end
      if (next_pulse) begin
         next_flag = 1'b1;
      end
   end

   always_comb begin
      next_rdata = '0;
      if (rd) begin
         case (addr)
            ADR_COUNT: next_rdata = period_count;
            ADR_LIMIT: next_rdata = period_limit;
            ADR_CTRL: begin
               next_rdata[CTRL_RUN] = run_bit;
               next_rdata[CTRL_PRE_LSB +: PRE_W] = pre_sel;
               next_rdata[CTRL_POST_LSB +: POST_W] = postscale_match_value;
            end
            ADR_MODE: next_rdata[MODE_W-1:0] = limit_mode_control;
            ADR_STAT: begin
               next_rdata[STAT_FLAG] = period_flag;
               next_rdata[STAT_RUN] = (state == ST_RUN);
               next_rdata[STAT_WAIT] = (state == ST_WAIT);
            end
            default: next_rdata = '0;
         endcase
      end
   end

   always_ff @(posedge clock or negedge nrst) begin
      if (!nrst) begin
         period_count <= COUNT_RST;
         period_limit <= LIMIT_RST;
         run_bit <= CTRL_RST[CTRL_RUN];
         pre_sel <= CTRL_RST[CTRL_PRE_LSB +: PRE_W];
         postscale_match_value <= CTRL_RST[CTRL_POST_LSB +: POST_W];
         limit_mode_control <= MODE_RST;
         post_cnt <= '0;
         period_event_pulse <= 1'b0;
         period_flag <= 1'b0;
         rdata <= '0;
         state <= ST_IDLE;
      end else begin
         period_count <= next_period_count;
         period_limit <= next_period_limit;
         run_bit <= next_run_bit;
         pre_sel <= next_pre_sel;
         postscale_match_value <= next_postscale_match_value;
         limit_mode_control <= next_limit_mode_control;
         post_cnt <= next_post_cnt;
         period_event_pulse <= next_pulse;
         period_flag <= next_flag;
         rdata <= next_rdata;
         state <= next_state;
      end
   end

   assign count_value = period_count;

   // ************************************************************
   // Assertions
   // ************************************************************
   default clocking cb @(posedge clock);
   endclocking
   default disable iff (!nrst);

   sequence s_plain_tick;
      tick && !match && !wr_count && !rst_act;
   endsequence

   sequence s_match;
      match && !wr_count && !rst_act;
   endsequence

   a_tick_advance: assert property (
      s_plain_tick |=> period_count == DATA_W'($past(period_count) + 8'h01))
      else $error("count did not advance on tick");

   a_match_clear: assert property (
      s_match |=> period_count == 8'h00)
      else $error("count not cleared after match");

   a_post_pulse: assert property (
      s_match ##0 (post_hit && !pi.clear) |=> period_event_pulse)
      else $error("period pulse missing after postscaler hit");

   // Back to back pulses are legal at limit zero, 1:1 and 1:1
   a_pulse_only: assert property (
      !(match && post_hit && !pi.clear) |=> !period_event_pulse)
      else $error("period pulse without a postscaler hit");

   a_ctrl_clear: assert property (
      wr_ctrl |=> post_cnt == 4'h0)
      else $error("control write did not clear postscaler");

   a_ctrl_keep: assert property (
      wr_ctrl && !rst_act |=> $stable(period_count))
      else $error("control write changed the count");

   a_gate_hold: assert property (
      gate_mode && !gate_ok && !wr_count |=> $stable(period_count))
      else $error("count moved while gate inactive");

   a_level_reset: assert property (
      rst_act && !wr_count |=> period_count == 8'h00)
      else $error("timer reset did not clear count");

   a_oneshot_stop: assert property (
      s_match ##0 (fam == FAM_ONE && !wr_ctrl) |=> !run_bit ##1
      state == ST_IDLE)
      else $error("one-shot did not stop at match");

   a_mono_wait: assert property (
      s_match ##0 (fam == FAM_MONO && !wr_ctrl && run_bit) |=>
      run_bit && state == ST_WAIT)
      else $error("monostable did not halt with run bit kept");

   a_freeze_ignore: assert property (
      debug_freeze && state == ST_WAIT |=> state != ST_RUN)
      else $error("trigger acted on during freeze");

   a_flag_set: assert property (
      period_event_pulse |-> period_flag)
      else $error("period flag not set with pulse");
endmodule

// *** tb/ept_far_model.sv ***
/*
 * Far side model: the peripheral that drives the external trigger line
 * and consumes period event pulses, counting them.
 * Assumes the timer clock and its reset; the bench calls drive().
 */
`timescale 1ns/10ps
module ept_far_model (
   // Clock and reset
   input wire logic clock,
   input wire logic nrst,
   // Timer side
   input wire logic period_event_pulse,
   output logic external_reset_signal,
   output int pulses
);
   import ept_pkg::*;

   initial external_reset_signal = 1'b0;

   always @(posedge clock or negedge nrst) begin
      if (!nrst) begin
         pulses <= 0;
      end else if (period_event_pulse === 1'b1) begin
         pulses <= pulses + 1;
      end
   end

   // Every change is held at least the edge gap, which also covers
   // the level minimum; shorter holds would risk a missed trigger
   task automatic drive(input logic lvl, input int hold);
      int h;
      h = (hold < ERS_EDGE_GAP_CYC) ? ERS_EDGE_GAP_CYC : hold;
      @(posedge clock);
      external_reset_signal <= lvl;
      repeat (h) @(posedge clock);
      // Return off the edge so callers see settled outputs
      #1;
   endtask
endmodule

// *** tb/test_eight_bit_period_timer.sv ***
/*
 * Self-checking bench for the period timer: register rows, period
 * configurations, scaler clears, one-shot, monostable, gate, reset
 * modes, freeze and a mid-run reset.
 * Assumes the far side model drives the trigger line.
 */
`timescale 1ns/10ps
module test_eight_bit_period_timer;
   import ept_pkg::*;

   // ************************************************************
   // Signals
   // ************************************************************
   typedef struct {logic w; logic [2:0] a; logic [7:0] d;} ept_row_s;
   typedef struct {logic [7:0] lim; int pre; int post;} ept_cfg_s;
   logic clock = 1'b0;
   logic nrst = 1'b0;
   logic [ADDR_W-1:0] addr = 3'h0;
   logic [DATA_W-1:0] wdata = 8'h00;
   logic wr = 1'b0;
   logic rd = 1'b0;
   logic debug_freeze = 1'b0;
   logic [DATA_W-1:0] rdata;
   logic external_reset_signal;
   logic period_event_pulse;
   logic period_flag;
   logic [DATA_W-1:0] count_value;
   int pulses;
   int miscompares = 0;
   int compares = 0;

   always #12.5 clock = ~clock;

   ept_timer dut_u (.clock(clock), .nrst(nrst), .addr(addr),
      .wdata(wdata), .wr(wr), .rd(rd), .rdata(rdata),
      .external_reset_signal(external_reset_signal),
      .debug_freeze(debug_freeze),
      .period_event_pulse(period_event_pulse),
      .period_flag(period_flag), .count_value(count_value));

   ept_far_model far_u (.clock(clock), .nrst(nrst),
      .period_event_pulse(period_event_pulse),
      .external_reset_signal(external_reset_signal), .pulses(pulses));

   // ************************************************************
   // Tasks
   // ************************************************************
   task automatic chk(input logic [15:0] got, input logic [15:0] exp);
      compares++;
      if (got !== exp) begin
         miscompares++;
         $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask

   task automatic wr_reg(input logic [2:0] a, input logic [7:0] d);
      @(posedge clock);
      addr <= a;
      wdata <= d;
      wr <= 1'b1;
      @(posedge clock);
      wr <= 1'b0;
   endtask

   task automatic rd_reg(input logic [2:0] a, output logic [7:0] d);
      @(posedge clock);
      addr <= a;
      rd <= 1'b1;
      @(posedge clock);
      rd <= 1'b0;
      #1;
      d = rdata;
   endtask

   task automatic cyc(input int n);
      repeat (n) @(posedge clock);
      #1;
   endtask

   task automatic wait_pulse(input int lim, output int n);
      n = 0;
      do begin
         @(posedge clock);
         #1;
         n++;
      end while (period_event_pulse !== 1'b1 && n < lim);
   endtask

   task automatic tally_and_finish;
      $display("compares=%0d miscompares=%0d", compares, miscompares);
      if (miscompares == 0 && compares > 0) begin
         $display("Simulation passed");
      end else begin
         $display("Simulation failed");
      end
      $finish;
   endtask

   // ************************************************************
   // Tests
   // ************************************************************
   ept_row_s rows [14] = '{
      '{0, ADR_COUNT, COUNT_RST}, '{0, ADR_LIMIT, LIMIT_RST},
      '{0, ADR_CTRL, CTRL_RST}, '{0, ADR_MODE, 8'h00},
      '{0, ADR_STAT, 8'h00}, '{0, 3'h5, 8'h00},
      '{1, ADR_COUNT, 8'h5a}, '{0, ADR_COUNT, 8'h5a},
      '{1, ADR_LIMIT, 8'h3c}, '{0, ADR_LIMIT, 8'h3c},
      '{1, 3'h6, 8'hff}, '{0, 3'h6, 8'h00},
      '{1, ADR_MODE, 8'h1f}, '{0, ADR_MODE, 8'h1f}};
   ept_cfg_s cfgs [5] = '{'{8'h02, 0, 0}, '{8'h03, 1, 1},
      '{8'h01, 7, 0}, '{8'h00, 0, 15}, '{8'h04, 2, 3}};

   initial begin
      #(25 * 20000);
      miscompares++;
      tally_and_finish();
   end

   initial begin
      logic [7:0] d;
      logic [7:0] v;
      int n;
      int p0;
      repeat (3) @(posedge clock);
      nrst <= 1'b1;
      foreach (rows[i]) begin
         if (rows[i].w) begin
            wr_reg(rows[i].a, rows[i].d);
         end else begin
            rd_reg(rows[i].a, d);
            chk(d, rows[i].d);
         end
      end
      wr_reg(ADR_MODE, 8'h00);
      wr_reg(ADR_CTRL, 8'h70);
      cyc(3);
      chk(count_value, 8'h5a);
      foreach (cfgs[i]) begin
         wr_reg(ADR_COUNT, 8'h00);
         wr_reg(ADR_LIMIT, cfgs[i].lim);
         wr_reg(ADR_CTRL, 8'(8'h80 | (cfgs[i].pre << 4) | cfgs[i].post));
         wait_pulse(2000, n);
         wait_pulse(2000, n);
         chk(16'(n), 16'((cfgs[i].lim + 1) * (1 << cfgs[i].pre)
            * (cfgs[i].post + 1)));
         wr_reg(ADR_CTRL, 8'h00);
      end
      rd_reg(ADR_STAT, d);
      chk(d & 8'h01, 8'h01);
      wr_reg(ADR_STAT, 8'h01);
      rd_reg(ADR_STAT, d);
      chk(d & 8'h01, 8'h00);
      // Rewrites come faster than one full postscale cycle
      wr_reg(ADR_LIMIT, 8'h00);
      wr_reg(ADR_CTRL, 8'h8f);
      p0 = pulses;
      for (int i = 0; i < 12; i++) begin
         cyc(8);
         if (i < 6) wr_reg(ADR_CTRL, 8'h8f);
         else wr_reg(ADR_COUNT, 8'h00);
      end
      chk(16'(pulses - p0), 16'h0000);
      cyc(40);
      chk(16'(pulses - p0 != 0), 16'h0001);
      wr_reg(ADR_CTRL, 8'h00);
      wr_reg(ADR_COUNT, 8'h00);
      wr_reg(ADR_LIMIT, 8'h03);
      wr_reg(ADR_MODE, 8'h08);
      wr_reg(ADR_CTRL, 8'h80);
      p0 = pulses;
      cyc(40);
      chk(16'(pulses - p0), 16'h0001);
      rd_reg(ADR_CTRL, d);
      chk(d & 8'h80, 8'h00);
      wr_reg(ADR_CTRL, 8'h80);
      cyc(40);
      chk(16'(pulses - p0), 16'h0002);
      wr_reg(ADR_CTRL, 8'h00);
      wr_reg(ADR_MODE, 8'h11);
      wr_reg(ADR_CTRL, 8'h80);
      p0 = pulses;
      cyc(20);
      chk(16'(pulses - p0), 16'h0000);
      far_u.drive(1'b1, 6);
      cyc(30);
      chk(16'(pulses - p0), 16'h0001);
      rd_reg(ADR_CTRL, d);
      chk(d & 8'h80, 8'h80);
      far_u.drive(1'b0, 6);
      far_u.drive(1'b1, 6);
      cyc(30);
      chk(16'(pulses - p0), 16'h0002);
      wr_reg(ADR_CTRL, 8'h00);
      far_u.drive(1'b0, 6);
      // One-shot whose start edge also resets the count
      wr_reg(ADR_COUNT, 8'h10);
      wr_reg(ADR_LIMIT, 8'h40);
      wr_reg(ADR_MODE, 8'h0c);
      wr_reg(ADR_CTRL, 8'h80);
      cyc(10);
      chk(count_value, 8'h10);
      far_u.drive(1'b1, 6);
      chk(16'(count_value < 8'h08), 16'h0001);
      cyc(80);
      rd_reg(ADR_CTRL, d);
      chk(d & 8'h80, 8'h00);
      far_u.drive(1'b0, 6);
      wr_reg(ADR_COUNT, 8'h00);
      wr_reg(ADR_LIMIT, 8'hff);
      wr_reg(ADR_MODE, 8'h01);
      wr_reg(ADR_CTRL, 8'h80);
      cyc(20);
      chk(count_value, 8'h00);
      far_u.drive(1'b1, 20);
      far_u.drive(1'b0, 10);
      v = count_value;
      chk(16'(v != 8'h00), 16'h0001);
      cyc(20);
      chk(count_value, v);
      far_u.drive(1'b1, 10);
      chk(16'(count_value > v), 16'h0001);
      wr_reg(ADR_MODE, 8'h07);
      cyc(6);
      chk(count_value, 8'h00);
      far_u.drive(1'b0, 20);
      chk(16'(count_value > 8'h08), 16'h0001);
      far_u.drive(1'b1, 6);
      chk(count_value, 8'h00);
      wr_reg(ADR_MODE, 8'h04);
      far_u.drive(1'b0, 20);
      chk(16'(count_value > 8'h08), 16'h0001);
      far_u.drive(1'b1, 8);
      chk(16'(count_value < 8'h08), 16'h0001);
      far_u.drive(1'b0, 6);
      @(posedge clock);
      debug_freeze <= 1'b1;
      cyc(3);
      v = count_value;
      far_u.drive(1'b1, 8);
      chk(count_value, v);
      // Edges while frozen must not start a waiting monostable
      far_u.drive(1'b0, 6);
      wr_reg(ADR_CTRL, 8'h00);
      wr_reg(ADR_MODE, 8'h11);
      wr_reg(ADR_CTRL, 8'h80);
      far_u.drive(1'b1, 8);
      rd_reg(ADR_STAT, d);
      chk(d & 8'h06, 8'h04);
      @(posedge clock);
      debug_freeze <= 1'b0;
      far_u.drive(1'b0, 6);
      far_u.drive(1'b1, 6);
      rd_reg(ADR_STAT, d);
      chk(d & 8'h06, 8'h02);
      wr_reg(ADR_LIMIT, 8'h20);
      @(posedge clock);
      nrst <= 1'b0;
      cyc(2);
      chk(count_value, COUNT_RST);
      chk(period_flag, 1'b0);
      @(posedge clock);
      nrst <= 1'b1;
      rd_reg(ADR_LIMIT, d);
      chk(d, LIMIT_RST);
      tally_and_finish();
   end
endmodule
